// ===== src/timer_pkg.sv
// Purpose: Shared constants for the timer module core.
// Assumes: 32-bit APB, one register per aligned word.
// Notes: Byte registers sit in the low bits, upper bits read zero.
package timer_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] CTRL0_OFS = 8'h00;
  localparam logic [7:0] CTRL1_OFS = 8'h04;
  localparam logic [7:0] CNT_L_OFS = 8'h08;
  localparam logic [7:0] CNT_H_OFS = 8'h0c;
  localparam logic [7:0] CMPA_L_OFS = 8'h10;
  localparam logic [7:0] CMPA_H_OFS = 8'h14;
  localparam logic [7:0] CMPP_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1c;
  // ==========================================================
  // Field positions
  localparam int PAUSE_BIT = 7;
  localparam int CLK_SEL_LSB = 4;
  localparam int ON_BIT = 3;
  localparam int CAP_SRC_BIT = 0;
  localparam int MODE_LSB = 6;
  localparam int PIN_FN_LSB = 4;
  localparam int INIT_BIT = 3;
  localparam int POL_BIT = 2;
  localparam int DUTY_SEL_BIT = 1;
  localparam int CLR_SEL_BIT = 0;
  localparam int FLAG_A = 0;
  localparam int FLAG_P = 1;
  localparam int FLAG_OVF = 2;
  localparam int FLAG_CAP = 3;
  // ==========================================================
  // Reset values and ratios
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] CMPA_RST = 16'h0000;
  localparam logic [7:0] CMPP_RST = 8'h00;
  localparam int SYS_DIV = 4;
  localparam int HIGH_DIV_A = 16;
  localparam int HIGH_DIV_B = 64;
  // ==========================================================
  // Modes
  typedef enum logic [1:0] {
    MODE_CMP = 2'b00, MODE_CAP = 2'b01, MODE_PWM = 2'b10, MODE_TMR = 2'b11
  } mode_t;
endpackage : timer_pkg

// ===== src/tick_divider.sv
// Purpose: Divides a tick stream by a fixed ratio.
// Assumes: tick_in is a one-cycle pulse in the pclk domain.
// Notes: Output is a registered one-cycle pulse.
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
  parameter int DIV = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick_in,
  output logic tick_out
);
  logic [$clog2(DIV)-1:0] cnt;
  // ==========================================================
  // Divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (cnt == $clog2(DIV)'(DIV - 1)) begin
          cnt <= '0;
          tick_out <= 1'b1;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end
endmodule : tick_divider
`default_nettype wire

// ===== src/timer_core.sv
// Purpose: 16-bit timer module core with APB registers.
// Assumes: Pins and tick inputs synchronous to pclk.
// Notes: Low bytes move through one shared byte buffer.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Counter equal to a comparator flags a match, interrupts, may clear and drive pin
// - Clock select picks sys ratio, high clock ratio, sub clock or external pin
// - External clock counts on rising or falling edge per clock select
// - Single pulse mode uses the external clock pin as start trigger
// - Separate interrupt outputs for comparator A and comparator P matches
// - Capture on rising, falling or both edges per pin function field
// - Compare match output mode drives pin high, low or toggles on match
// - Inverted output pin is always the inverse of the main output
// - PWM leaves on the same main and inverted output pin pair
// - Edge aligned PWM, comparators set either duty or period
// - High bytes accessed directly, low bytes move via buffer on high access
// - Comparator low byte write only loads the shared buffer
// - Comparator high byte write also copies buffer into low byte
// - High byte read returns high byte and latches low byte into buffer
// - Low byte read returns the shared buffer contents
// - Periodic type may capture from its external clock pin instead
// - 16-bit up counter, A compares 16 bits, P compares upper 8 bits
// - Counter cleared by off-to-on change, overflow or comparator match
module timer_core
  import timer_pkg::*;
#(
  parameter bit PERIODIC = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic high_clock_tick,
  input wire logic sub_clock_tick,
  input wire logic ext_clock_pin,
  input wire logic capture_pin,
  output logic out_pin,
  output logic out_inv_pin,
  output logic int_match_a,
  output logic int_match_p
);
  logic [7:0] ctrl0, ctrl1, cmp_p, byte_buf;
  logic [15:0] count, cmp_a;
  logic [3:0] flags;
  logic on_d, ext_d, cap_d, out_level, pulse_run;
  logic sys4_tick, high16_tick, high64_tick;
  logic timer_on, pause, duty_sel, clr_sel;
  logic [2:0] clk_sel;
  logic [1:0] pin_fn;
  mode_t mode;
  logic done, wr_done, rd_done, rd_take, on_rise;
  logic ext_rise, ext_fall, src_tick, cnt_tick, sp_start;
  logic eq_a, eq_p, clr_hit, match_a, match_p, in_duty;
  logic cap_rise, cap_fall, cap_evt, ovf;
  logic [31:0] next_rdata;
  logic next_err;

  // ==========================================================
  // Field decode
  assign timer_on = ctrl0[ON_BIT];
  assign pause = ctrl0[PAUSE_BIT];
  assign clk_sel = ctrl0[CLK_SEL_LSB +: 3];
  assign mode = mode_t'(ctrl1[MODE_LSB +: 2]);
  assign pin_fn = ctrl1[PIN_FN_LSB +: 2];
  assign duty_sel = ctrl1[DUTY_SEL_BIT];
  assign clr_sel = ctrl1[CLR_SEL_BIT];
  assign done = psel & penable & pready;
  assign wr_done = done & pwrite & ~pslverr;
  assign rd_done = done & ~pwrite & ~pslverr;
  // High byte and buffered low byte are taken on one edge so a read never tears
  assign rd_take = psel & penable & ~pready & ~pwrite;
  assign on_rise = timer_on & ~on_d;

  function automatic logic hit(input logic [7:0] ofs);
    hit = (paddr == ofs);
  endfunction : hit

  // ==========================================================
  // Clock sources
  tick_divider #(.DIV(SYS_DIV)) u_sys4 (
    .pclk(pclk), .presetn(presetn), .tick_in(1'b1), .tick_out(sys4_tick)
  );
  tick_divider #(.DIV(HIGH_DIV_A)) u_high16 (
    .pclk(pclk), .presetn(presetn), .tick_in(high_clock_tick), .tick_out(high16_tick)
  );
  tick_divider #(.DIV(HIGH_DIV_B)) u_high64 (
    .pclk(pclk), .presetn(presetn), .tick_in(high_clock_tick), .tick_out(high64_tick)
  );

  assign ext_rise = ext_clock_pin & ~ext_d;
  assign ext_fall = ~ext_clock_pin & ext_d;

  always_comb begin
    unique case (clk_sel)
      3'h0: src_tick = sys4_tick;
      3'h1: src_tick = 1'b1;
      3'h2: src_tick = high16_tick;
      3'h3: src_tick = high64_tick;
      3'h4, 3'h5: src_tick = sub_clock_tick;
      3'h6: src_tick = ext_rise;
      3'h7: src_tick = ext_fall;
    endcase
  end

  // ==========================================================
  // Counter and comparators
  // Single pulse holds the counter until a trigger arrives
  assign sp_start = timer_on & (mode == MODE_PWM) & (pin_fn == 2'b11) & ext_rise & ~pulse_run;
  // No match on the stale count in the cycle that switches the timer on
  assign cnt_tick = timer_on & ~pause & src_tick & ~on_rise
                  & ~((mode == MODE_PWM) & (pin_fn == 2'b11) & ~pulse_run);
  assign eq_a = (count == cmp_a);
  // P value 0 stands for a full 65536-count period
  assign eq_p = (count == {cmp_p - 8'h01, 8'hff});
  assign match_a = cnt_tick & eq_a;
  assign match_p = cnt_tick & eq_p;
  assign ovf = cnt_tick & (count == 16'hffff);
  always_comb begin
    if (mode == MODE_PWM) begin
      clr_hit = duty_sel ? eq_a : eq_p;
    end else if (mode == MODE_CAP) begin
      clr_hit = 1'b0;
    end else begin
      clr_hit = clr_sel ? eq_a : eq_p;
    end
  end
  assign in_duty = duty_sel ? (count[15:8] < cmp_p) : (count < cmp_a);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
    end else if (on_rise || sp_start) begin
      count <= 16'h0000;
    end else if (cnt_tick) begin
      if (clr_hit) begin
        count <= 16'h0000;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_d <= 1'b0;
      ext_d <= 1'b0;
      cap_d <= 1'b0;
    end else begin
      on_d <= timer_on;
      ext_d <= ext_clock_pin;
      cap_d <= capture_pin;
    end
  end

  // ==========================================================
  // Capture
  always_comb begin
    if (PERIODIC && ctrl0[CAP_SRC_BIT]) begin
      cap_rise = ext_rise;
      cap_fall = ext_fall;
    end else begin
      cap_rise = capture_pin & ~cap_d;
      cap_fall = ~capture_pin & cap_d;
    end
  end
  always_comb begin
    unique case (pin_fn)
      2'b00: cap_evt = cap_rise;
      2'b01: cap_evt = cap_fall;
      2'b10: cap_evt = cap_rise | cap_fall;
      2'b11: cap_evt = 1'b0;
    endcase
    cap_evt = cap_evt & timer_on & (mode == MODE_CAP);
  end

  // ==========================================================
  // Output pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_run <= 1'b0;
    end else if (!timer_on || match_a) begin
      pulse_run <= 1'b0;
    end else if (sp_start) begin
      pulse_run <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_level <= 1'b0;
    end else if (on_rise) begin
      out_level <= ctrl1[INIT_BIT];
    end else if (mode == MODE_CMP) begin
      if (match_a) begin
        unique case (pin_fn)
          2'b00: out_level <= out_level;
          2'b01: out_level <= 1'b0;
          2'b10: out_level <= 1'b1;
          2'b11: out_level <= ~out_level;
        endcase
      end
    end else if (mode == MODE_PWM) begin
      unique case (pin_fn)
        2'b00: out_level <= ~ctrl1[INIT_BIT];
        2'b01: out_level <= ctrl1[INIT_BIT];
        2'b10: out_level <= in_duty ~^ ctrl1[INIT_BIT];
        2'b11: out_level <= pulse_run ~^ ctrl1[INIT_BIT];
      endcase
    end
  end

  // Both pins come from one level so they never skew apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_pin <= 1'b0;
      out_inv_pin <= 1'b1;
    end else begin
      out_pin <= out_level ^ ctrl1[POL_BIT];
      out_inv_pin <= ~(out_level ^ ctrl1[POL_BIT]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_match_a <= 1'b0;
      int_match_p <= 1'b0;
    end else begin
      int_match_a <= match_a;
      int_match_p <= match_p;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0 <= CTRL_RST;
      ctrl1 <= CTRL_RST;
      cmp_p <= CMPP_RST;
    end else if (wr_done) begin
      if (hit(CTRL0_OFS)) ctrl0 <= pwdata[7:0];
      if (hit(CTRL1_OFS)) ctrl1 <= pwdata[7:0];
      if (hit(CMPP_OFS)) cmp_p <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_a <= CMPA_RST;
    end else if (wr_done && hit(CMPA_H_OFS)) begin
      cmp_a <= {pwdata[7:0], byte_buf};
    end else if (cap_evt) begin
      cmp_a <= count;
    end
  end

  // A low byte write touches only the buffer; order errors are software's
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_buf <= 8'h00;
    end else if (wr_done && hit(CMPA_L_OFS)) begin
      byte_buf <= pwdata[7:0];
    end else if (rd_take && hit(CNT_H_OFS)) begin
      byte_buf <= count[7:0];
    end else if (rd_take && hit(CMPA_H_OFS)) begin
      byte_buf <= cmp_a[7:0];
    end
  end

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= 4'h0;
    end else begin
      flags <= (flags & ~((wr_done && hit(STATUS_OFS)) ? pwdata[3:0] : 4'h0))
             | {cap_evt, ovf, match_p, match_a};
    end
  end

  // ==========================================================
  // APB slave, one wait state
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    unique case (paddr)
      CTRL0_OFS: next_rdata[7:0] = ctrl0;
      CTRL1_OFS: next_rdata[7:0] = ctrl1;
      CNT_L_OFS: next_rdata[7:0] = byte_buf;
      CNT_H_OFS: next_rdata[7:0] = count[15:8];
      CMPA_L_OFS: next_rdata[7:0] = byte_buf;
      CMPA_H_OFS: next_rdata[7:0] = cmp_a[15:8];
      CMPP_OFS: next_rdata[7:0] = cmp_p;
      STATUS_OFS: next_rdata[4:0] = {pulse_run, flags};
      default: next_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= next_err;
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_inv_pin: assert property (out_inv_pin == ~out_pin) else $error("pins not inverse");
  a_on_clear: assert property ($rose(timer_on) |=> count == 16'h0000) else $error("no clear on start");
  a_count_step: assert property (cnt_tick && !clr_hit && !on_rise && !sp_start
    |=> count == $past(count) + 16'h0001) else $error("bad increment");
  a_hold_idle: assert property (!timer_on && !on_d |=> $stable(count)) else $error("count moved while off");
  a_irq_a: assert property (cnt_tick && eq_a |=> int_match_a ##1 !int_match_a || $past(match_a))
    else $error("missing A interrupt");
  a_irq_p: assert property (cnt_tick && eq_p |=> int_match_p && flags[FLAG_P]) else $error("missing P interrupt");
  a_low_write: assert property (wr_done && hit(CMPA_L_OFS) && !cap_evt
    |=> $stable(cmp_a) && byte_buf == $past(pwdata[7:0])) else $error("low write leaked");
  a_high_write: assert property (wr_done && hit(CMPA_H_OFS)
    |=> cmp_a == {$past(pwdata[7:0]), $past(byte_buf)}) else $error("high write wrong");
  a_high_read: assert property (rd_done && hit(CNT_H_OFS)
    |-> prdata[7:0] == $past(count[15:8]) && byte_buf == $past(count[7:0])) else $error("high read wrong");
  a_low_read: assert property (rd_done && hit(CNT_L_OFS) |-> prdata[7:0] == byte_buf) else $error("low read wrong");
  a_cmp_set: assert property (mode == MODE_CMP && match_a && pin_fn == 2'b10 && !on_rise
    |=> out_level ##1 out_pin == !ctrl1[POL_BIT]) else $error("set on match failed");
  a_capture: assert property (cap_evt && !(wr_done && hit(CMPA_H_OFS))
    |=> cmp_a == $past(count) && flags[FLAG_CAP]) else $error("capture lost");

  c_match_a: cover property (mode == MODE_CMP && match_a);
  c_capture: cover property (cap_evt);
  c_pulse: cover property (sp_start ##[1:300] match_a);
  c_pwm: cover property (mode == MODE_PWM && pin_fn == 2'b10 && clr_hit && cnt_tick);
endmodule : timer_core
`default_nettype wire

// ===== testbench/clock_sources.sv
// Purpose: Far side tick and external clock sources for the timer core.
// Assumes: One pclk domain; all outputs change right after a rising edge.
// Notes: External clock stands still low while not running.
`timescale 1ns/1ns
`default_nettype none
module clock_sources (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ext_run,
  output logic high_clock_tick,
  output logic sub_clock_tick,
  output logic ext_clock_pin
);
  // ==========================================================
  // Tick generators
  logic [2:0] phase;
  logic [1:0] ext_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 3'h0;
      ext_cnt <= 2'h0;
      ext_clock_pin <= 1'b0;
    end else begin
      phase <= phase + 3'h1;
      // Idle low between runs so no stray edge is counted
      ext_cnt <= (!ext_run || ext_cnt == 2'h2) ? 2'h0 : ext_cnt + 2'h1;
      if (!ext_run) ext_clock_pin <= 1'b0;
      else if (ext_cnt == 2'h2) ext_clock_pin <= !ext_clock_pin;
    end
  end
  assign high_clock_tick = phase[0];
  assign sub_clock_tick = (phase == 3'h7);
endmodule : clock_sources
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the timer core.
// Assumes: One wait state APB slave; ticks from clock_sources.
// Notes: Expected figures come from the small models below.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import timer_pkg::*;
  // ==========================================================
  // Signals
  logic pclk, presetn, psel, penable, pwrite, capture_pin, ext_run;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, last_err, out_pin, out_inv_pin, int_match_a, int_match_p;
  logic high_clock_tick, sub_clock_tick, ext_clock_pin, o1;
  logic [7:0] rnd;
  int error_cnt, tests_run, iv, hi, bad;
  int div_tab[8] = '{4, 1, 32, 128, 8, 8, 6, 6};
  timer_core #(.PERIODIC(1'b0)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .high_clock_tick(high_clock_tick), .sub_clock_tick(sub_clock_tick), .ext_clock_pin(ext_clock_pin),
    .capture_pin(capture_pin), .out_pin(out_pin), .out_inv_pin(out_inv_pin),
    .int_match_a(int_match_a), .int_match_p(int_match_p));
  clock_sources i_src (.pclk(pclk), .presetn(presetn), .ext_run(ext_run), .high_clock_tick(high_clock_tick),
    .sub_clock_tick(sub_clock_tick), .ext_clock_pin(ext_clock_pin));
  // ==========================================================
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  function automatic logic exp_pin(input int fn, input logic init, input int nmatch);
    case (fn)
      1: return 1'b0;
      2: return 1'b1;
      3: return init ^ nmatch[0];
      default: return init;
    endcase
  endfunction : exp_pin
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cmp_a(input logic [15:0] v);
    apb(1'b1, CMPA_L_OFS, {24'h0, v[7:0]});
    apb(1'b1, CMPA_H_OFS, {24'h0, v[15:8]});
  endtask : cmp_a
  // Waits for one match, notes out_pin after it, then measures the gap to the next
  task automatic gap(input logic p);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((p ? int_match_p : int_match_a) !== 1'b1 && n < 4000);
    @(posedge pclk);
    @(posedge pclk);
    o1 = out_pin;
    iv = 2;
    do begin
      @(posedge pclk);
      iv++;
    end while ((p ? int_match_p : int_match_a) !== 1'b1 && iv < 4000);
  endtask : gap
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  // ==========================================================
  // Clock, reset and watchdog
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (80000) @(posedge pclk);
    error_cnt++;
    test_done;
  end
  // ==========================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, capture_pin, ext_run} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    rnd = 8'h16;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk("out_inv_rst", {31'h0, out_inv_pin}, 32'h1);
    foreach (div_tab[k]) begin
      apb(1'b0, 8'(k * 4), 32'h0);
      if (k != 2 && k != 3) chk("reg_rst", rd, 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", {31'h0, last_err}, 32'h1);
    // Shared low byte buffer
    rnd = lfsr(rnd);
    apb(1'b1, CMPA_L_OFS, {24'h0, rnd});
    apb(1'b0, CMPA_L_OFS, 32'h0);
    chk("buf_read", rd, {24'h0, rnd});
    apb(1'b1, CMPA_H_OFS, 32'h12);
    apb(1'b1, CMPA_L_OFS, {24'h0, ~rnd});
    apb(1'b0, CMPA_H_OFS, 32'h0);
    chk("cmpa_high", rd, 32'h12);
    apb(1'b0, CMPA_L_OFS, 32'h0);
    chk("cmpa_low", rd, {24'h0, rnd});
    // Compare match output per pin function
    for (int fn = 1; fn < 4; fn++) begin
      apb(1'b1, CTRL0_OFS, 32'h10);
      apb(1'b1, CTRL1_OFS, 32'((fn << 4) | 1));
      cmp_a(16'h0003);
      apb(1'b1, CTRL0_OFS, 32'h18);
      gap(1'b0);
      chk("period_a", iv, 32'd4);
      chk("pin_level", {31'h0, o1}, {31'h0, exp_pin(fn, 1'b0, 1)});
      chk("inv_pin", {31'h0, out_inv_pin}, {31'h0, ~out_pin});
    end
    // Counter reads through the buffer while running
    apb(1'b0, CNT_H_OFS, 32'h0);
    chk("cnt_high", rd, 32'h0);
    apb(1'b0, CNT_L_OFS, 32'h0);
    hi = rd;
    chk("cnt_low_range", {31'h0, rd < 32'h4}, 32'h1);
    repeat (7) @(posedge pclk);
    apb(1'b0, CNT_L_OFS, 32'h0);
    chk("cnt_buf_hold", rd, 32'(hi));
    // Pause freezes the count, so two full reads agree
    apb(1'b1, CTRL0_OFS, 32'h98);
    apb(1'b0, CNT_H_OFS, 32'h0);
    apb(1'b0, CNT_L_OFS, 32'h0);
    hi = rd;
    repeat (5) @(posedge pclk);
    apb(1'b0, CNT_H_OFS, 32'h0);
    apb(1'b0, CNT_L_OFS, 32'h0);
    chk("pause_hold", rd, 32'(hi));
    // Every clock source
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, CTRL0_OFS, 32'(s << 4));
      ext_run <= (s >= 6);
      apb(1'b1, CTRL0_OFS, 32'((s << 4) | 8));
      gap(1'b0);
      chk("clk_sel_period", iv, 32'(4 * div_tab[s]));
    end
    ext_run <= 1'b0;
    // Comparator P sees the upper byte only
    apb(1'b1, CTRL0_OFS, 32'h10);
    apb(1'b1, CTRL1_OFS, 32'h30);
    apb(1'b1, CMPP_OFS, 32'h2);
    apb(1'b1, CTRL0_OFS, 32'h18);
    gap(1'b1);
    chk("period_p", iv, 32'd512);
    // Edge aligned PWM, duty or period from each comparator
    for (int d = 0; d < 2; d++) begin
      apb(1'b1, CTRL0_OFS, 32'h10);
      apb(1'b1, CTRL1_OFS, 32'(8'ha8 | (d << 1)));
      cmp_a(d ? 16'h01ff : 16'h0040);
      apb(1'b1, CMPP_OFS, 32'h1);
      apb(1'b1, CTRL0_OFS, 32'h18);
      repeat (600) @(posedge pclk);
      hi = 0;
      bad = 0;
      repeat (512) begin
        @(posedge pclk);
        hi += (out_pin === 1'b1);
        bad += (out_inv_pin !== ~out_pin);
      end
      chk("pwm_high", hi, d ? 32'd256 : 32'd128);
      chk("pwm_inv", bad, 32'd0);
    end
    // Single pulse started by the external clock pin, active level high
    apb(1'b1, CTRL0_OFS, 32'h10);
    apb(1'b1, CTRL1_OFS, 32'hb8);
    cmp_a(16'h0009);
    apb(1'b1, CTRL0_OFS, 32'h18);
    repeat (4) @(posedge pclk);
    chk("pulse_idle", {31'h0, out_pin}, 32'h0);
    ext_run <= 1'b1;
    iv = 0;
    do begin
      @(posedge pclk);
      iv++;
    end while (out_pin !== 1'b1 && iv < 20);
    // Stop the pin before its next rising edge could retrigger
    ext_run <= 1'b0;
    hi = 1;
    repeat (40) begin
      @(posedge pclk);
      hi += (out_pin === 1'b1);
    end
    chk("pulse_len", hi, 32'd10);
    // Capture edge selection
    for (int fn = 0; fn < 4; fn++) begin
      apb(1'b1, CTRL0_OFS, 32'h10);
      apb(1'b1, CTRL1_OFS, 32'(8'h40 | (fn << 4)));
      apb(1'b1, CTRL0_OFS, 32'h18);
      for (int e = 1; e >= 0; e--) begin
        apb(1'b1, STATUS_OFS, 32'hf);
        capture_pin <= e[0];
        repeat (4) @(posedge pclk);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("cap_flag", {31'h0, rd[FLAG_CAP]}, 32'(fn == 2 || fn == (1 - e)));
      end
    end
    test_done;
  end
endmodule : tb_top
`default_nettype wire
